// ### inc/sfs_consts.svh
// Purpose: Timing counts and encodings for the start-up and fault sequencer.
// Assumes: Clock is the 25 MHz switching clock.
// Notes:   Definitions only; included by bare name.
`ifndef SFS_CONSTS_SVH
`define SFS_CONSTS_SVH

`define SFS_CLK_PERIOD_NS   40
`define SFS_START_DELAY_CYC 384
`define SFS_SS_CYC          1280
`define SFS_PG_FILT_CYC     3
`define SFS_GATE_OFF_NS     100
// Longest time, so rounded down; the shutdown path meets it in one cycle.
`define SFS_GATE_OFF_CYC    ((`SFS_GATE_OFF_NS) / (`SFS_CLK_PERIOD_NS))

// Reference-pin band code: 0 below 29 %, 1 up to 45 %, 2 up to 62 %, 3 above.
`define SFS_BAND_LOW        2'h0
`define SFS_BAND_MIDLOW     2'h1
`define SFS_BAND_MIDHIGH    2'h2
`define SFS_BAND_HIGH       2'h3

// Channel-two phase in degrees; positive lags channel one, negative leads.
`define SFS_PH_DDR          (-10'sd60)
`define SFS_PH_0            10'sd0
`define SFS_PH_90           10'sd90
`define SFS_PH_180          10'sd180
`define SFS_PH_240          10'sd240

`endif

// ### inc/sfs_pkg.sv
// Purpose: Types shared by the start-up and fault sequencer.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   Constants live in sfs_consts.svh.
package sfs_pkg;

  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_WAIT,
    SEQ_DELAY,
    SEQ_SOFT,
    SEQ_RUN
  } sfs_seq_t;

endpackage

// ### rtl/sfs_sequencer.sv
// Purpose: Start-up delay, dual soft-start, power-good and OV/UV handling.
// Assumes: sys_clk is the switching clock; comparator levels arrive as inputs.
// Notes:   Gate outputs are permits to the PWM stage, not the PWM itself.
//
// Overview of operation
// RULE_01 - Start after enable, supplies and PLL lock, plus 384 clock delay.
// RULE_02 - Shutdown or fault resets soft-start, gates off within 100 ns. Synchronised faults reach the gates on the third edge, undervoltage on the fourth.
// RULE_03 - Enable sink current is on until the channel is enabled.
// RULE_04 - Faults pull the shared enable/fault line low internally.
// RULE_05 - Any member pulling the shared line low turns every controller off.
// RULE_06 - Two independent soft-start counters, each 1280 switching cycles.
// RULE_07 - Precharged output holds switching until feedback meets reference or ramp ends.
// RULE_08 - One power-good output, low when either channel is out of regulation.
// RULE_09 - Power-good waits for both soft-starts and is gated by both enables.
// RULE_10 - Power-good drops only after three consecutive out-of-window cycles.
// RULE_11 - Above 120 percent latches off; low gate on until below 87 percent.
// RULE_12 - Latched overvoltage forces line and power-good low until supply cycles.
// RULE_13 - Overvoltage per channel in dual mode, both channels in multiphase mode.
// RULE_14 - Line low and above 113 percent turns low gate on until 87 percent.
// RULE_15 - Undervoltage detection stays off until soft-start ends.
// RULE_16 - Undervoltage turns low gates off unless caused by OV, OC, OT or PLL.
// RULE_17 - Channel-two phase: positive value lags channel one, negative leads.
// RULE_18 - Integrator ties every enable/fault line onto one shared net.
// RULE_19 - Sense-minus near supply with feedback two grounded selects 2-phase 180 degrees.
// RULE_20 - Comparator levels are synchronised before any counter, filter or latch; supply and line levels reach the run permit unsynchronised.
`timescale 1ns/100ps
`default_nettype none
`include "sfs_consts.svh"

module sfs_sequencer #(
  parameter int DELAY_CYCLES = `SFS_START_DELAY_CYC,
  parameter int SS_CYCLES    = `SFS_SS_CYC,
  parameter int PG_CYCLES    = `SFS_PG_FILT_CYC,
  parameter int SS_W         = $clog2(SS_CYCLES + 1)
) (
  input  wire logic                 sys_clk,                // Switching clock.
  input  wire logic                 rst_n,                  // Power-on reset, active low.
  input  wire logic                 vcc_por_ok,             // Bias supply above its POR.
  input  wire logic                 driver_bias_supply_ok,  // Driver supply above its POR.
  input  wire logic                 pll_locked,             // PLL lock time elapsed.
  input  wire logic [1:0]           enable_fault_line_in,   // Line level above 0.8 V.
  output var  logic [1:0]           enable_fault_line_out,  // Driven level, always low.
  output var  logic [1:0]           enable_fault_line_oe,   // High while pulling low.
  output var  logic [1:0]           en_sink_on,             // Hysteresis sink enable.
  input  wire logic [1:0]           mon_ov120,              // Output above 120 %.
  input  wire logic [1:0]           mon_ov113,              // Output above 113 %.
  input  wire logic [1:0]           mon_below87,            // Output below 87 %.
  input  wire logic [1:0]           mon_uv,                 // Output 13 % below target.
  input  wire logic [1:0]           mon_out_of_window,      // Outside power-good window.
  input  wire logic [1:0]           fb_above_ss_ref,        // Feedback above ramp.
  input  wire logic [1:0]           oc_fault,               // Overcurrent per channel.
  input  wire logic                 ot_fault,               // Over-temperature.
  input  wire logic                 pll_fault,              // PLL failure.
  input  wire logic                 ch2_neg_sense_near_vcc, // Sense-minus within 400 mV.
  input  wire logic                 ch2_feedback_grounded,  // Channel-two feedback at ground.
  input  wire logic                 ch2_pos_sense_high,     // Channel-two sense-plus high.
  input  wire logic [1:0]           ref_pin_band,           // Reference-pin voltage band.
  output var  logic [1:0]           high_side_gate,         // High-side gate permit.
  output var  logic [1:0]           low_side_gate,          // Low-side gate permit.
  output var  logic [1:0][SS_W-1:0] ss_ref,                 // Soft-start reference count.
  output var  logic [1:0]           ss_done,                // Soft-start complete.
  output var  logic [1:0]           ov_latched,             // Overvoltage latch.
  output var  logic                 power_good_out,         // Shared power-good.
  output var  logic                 two_phase_mode,         // 2-phase single output.
  output var  logic                 multiphase_mode,        // Channels act as phases.
  output var  logic signed [9:0]    ch2_phase_deg           // Channel-two phase.
);

  localparam int DLY_W = $clog2(DELAY_CYCLES + 1);
  localparam int PG_W  = $clog2(PG_CYCLES + 1);
  localparam int NSYNC = 24;

  // Reset: asynchronous assertion, release through two flops.
  logic [1:0] rst_pipe_q;
  logic       rst_sync_n;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe_q <= 2'h0;
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end

  assign rst_sync_n = rst_pipe_q[1];

  // Comparator synchronisation.
  logic [NSYNC-1:0] sync_q;
  logic             pll_s;
  logic [1:0]       en_s;
  logic [1:0]       ov120_s;
  logic [1:0]       ov113_s;
  logic [1:0]       b87_s;
  logic [1:0]       uv_s;
  logic [1:0]       pgbad_s;
  logic [1:0]       fbhi_s;
  logic [1:0]       oc_s;
  logic             ot_s;
  logic             pllf_s;
  logic             nearvcc_s;
  logic             fb2gnd_s;
  logic             vsp_s;
  logic [1:0]       band_s;

  sfs_sync #(
    .W (NSYNC)
  ) u_sync (
    .clk   (sys_clk),
    .rst_n (rst_sync_n),
    .d     ({ref_pin_band, ch2_pos_sense_high, ch2_feedback_grounded,
             ch2_neg_sense_near_vcc, pll_fault, ot_fault, oc_fault,
             fb_above_ss_ref, mon_out_of_window, mon_uv, mon_below87,
             mon_ov113, mon_ov120, enable_fault_line_in, pll_locked}),
    .q     (sync_q)
  ); // [RULE_20]

  assign {band_s, vsp_s, fb2gnd_s, nearvcc_s, pllf_s, ot_s, oc_s, fbhi_s,
          pgbad_s, uv_s, b87_s, ov113_s, ov120_s, en_s, pll_s} = sync_q;

  // Mode decode from the channel-two straps.
  logic multi_q;

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      multi_q        <= 1'b0;
      two_phase_mode <= 1'b0;
    end else begin
      multi_q        <= nearvcc_s;
      two_phase_mode <= nearvcc_s & fb2gnd_s; // [RULE_19]
    end
  end

  assign multiphase_mode = multi_q;

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ch2_phase_deg <= `SFS_PH_0;
    end else if (nearvcc_s) begin
      if (fb2gnd_s || vsp_s) begin
        ch2_phase_deg <= `SFS_PH_180; // [RULE_17]
      end else begin
        ch2_phase_deg <= `SFS_PH_240;
      end
    end else begin
      unique case (band_s)
        `SFS_BAND_LOW:     ch2_phase_deg <= `SFS_PH_DDR; // [RULE_17]
        `SFS_BAND_MIDLOW:  ch2_phase_deg <= `SFS_PH_0;
        `SFS_BAND_MIDHIGH: ch2_phase_deg <= `SFS_PH_90;
        `SFS_BAND_HIGH:    ch2_phase_deg <= `SFS_PH_180;
      endcase
    end
  end

  // Shared fault causes. Pin inputs are synchronised, so the shutdown path
  // samples supply and line levels directly to stay inside one cycle.
  logic supply_ok;
  logic common_fault;
  logic any_ov120;

  assign supply_ok    = vcc_por_ok & driver_bias_supply_ok;
  assign common_fault = ot_s | pllf_s;
  assign any_ov120    = |ov120_s;

  logic [1:0]              pull_ch;
  logic [1:0]              pg_ok;
  logic [1:0]              uv_trip_q;
  logic [1:0]              ov_sink_q;
  logic [1:0]              nl_sink_q;
  logic [1:0]              hold_q;
  sfs_pkg::sfs_seq_t       state_q [2];
  logic [1:0][DLY_W-1:0]   dly_q;
  logic [1:0][PG_W-1:0]    pg_cnt_q;

  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic run_ok;
    logic ov_trip;
    logic ramping;

    // Any lost supply, line low, latch or fault stops the channel at once.
    assign run_ok  = supply_ok & enable_fault_line_in[c] & ~ov_latched[c] &
                     ~pull_ch[c]; // [RULE_02] [RULE_05]
    assign ov_trip = multi_q ? any_ov120 : ov120_s[c]; // [RULE_13]
    assign ramping = (state_q[c] == sfs_pkg::SEQ_SOFT) |
                     (state_q[c] == sfs_pkg::SEQ_RUN);

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        state_q[c] <= sfs_pkg::SEQ_IDLE;
        dly_q[c]   <= '0;
        ss_ref[c]  <= '0;
      end else if (!run_ok) begin
        state_q[c] <= sfs_pkg::SEQ_IDLE; // [RULE_02]
        dly_q[c]   <= '0;
        ss_ref[c]  <= '0;
      end else begin
        unique case (state_q[c])
          sfs_pkg::SEQ_IDLE: begin
            state_q[c] <= sfs_pkg::SEQ_WAIT;
          end
          sfs_pkg::SEQ_WAIT: begin
            if (en_s[c] && pll_s) begin
              state_q[c] <= sfs_pkg::SEQ_DELAY; // [RULE_01]
            end
          end
          sfs_pkg::SEQ_DELAY: begin
            if (dly_q[c] == DLY_W'(DELAY_CYCLES - 1)) begin
              state_q[c] <= sfs_pkg::SEQ_SOFT; // [RULE_01]
            end else begin
              dly_q[c] <= dly_q[c] + DLY_W'(1);
            end
          end
          sfs_pkg::SEQ_SOFT: begin
            if (ss_ref[c] == SS_W'(SS_CYCLES - 1)) begin
              state_q[c] <= sfs_pkg::SEQ_RUN;
            end
            ss_ref[c] <= ss_ref[c] + SS_W'(1); // [RULE_06]
          end
          sfs_pkg::SEQ_RUN: begin
            state_q[c] <= sfs_pkg::SEQ_RUN;
          end
        endcase
      end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        ss_done[c]    <= 1'b0;
        en_sink_on[c] <= 1'b1;
      end else begin
        ss_done[c]    <= run_ok & (state_q[c] == sfs_pkg::SEQ_RUN);
        en_sink_on[c] <= ~run_ok | (state_q[c] == sfs_pkg::SEQ_IDLE) |
                         (state_q[c] == sfs_pkg::SEQ_WAIT); // [RULE_03]
      end
    end

    // A precharged output waits for the ramp to catch up with feedback.
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        hold_q[c] <= 1'b1;
      end else if (state_q[c] != sfs_pkg::SEQ_SOFT) begin
        hold_q[c] <= (state_q[c] == sfs_pkg::SEQ_DELAY) & fbhi_s[c];
      end else if (!fbhi_s[c]) begin
        hold_q[c] <= 1'b0; // [RULE_07]
      end
    end

    // Latched overvoltage, cleared only while the bias supply is gone.
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        ov_latched[c] <= 1'b0;
      end else if (ov_trip) begin
        ov_latched[c] <= 1'b1; // [RULE_11] [RULE_13]
      end else if (!vcc_por_ok) begin
        ov_latched[c] <= 1'b0; // [RULE_12]
      end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        ov_sink_q[c] <= 1'b0;
      end else if (ov_trip) begin
        ov_sink_q[c] <= 1'b1; // [RULE_11]
      end else if (b87_s[c]) begin
        ov_sink_q[c] <= 1'b0;
      end
    end

    // Non-latching crowbar while the shared line is low.
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        nl_sink_q[c] <= 1'b0;
      end else if (!en_s[c] && ov113_s[c]) begin
        nl_sink_q[c] <= 1'b1; // [RULE_14]
      end else if (b87_s[c]) begin
        nl_sink_q[c] <= 1'b0;
      end
    end

    // Undervoltage is armed only after the ramp, and only for its own cause.
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        uv_trip_q[c] <= 1'b0;
      end else if ((state_q[c] == sfs_pkg::SEQ_RUN) && uv_s[c] && en_s[c] &&
                   !ov113_s[c] && !ov120_s[c] && !oc_s[c] && !common_fault) begin
        uv_trip_q[c] <= 1'b1; // [RULE_15] [RULE_16]
      end else if (state_q[c] == sfs_pkg::SEQ_IDLE) begin
        uv_trip_q[c] <= 1'b0;
      end
    end

    assign pull_ch[c] = ov_latched[c] | oc_s[c] | common_fault | uv_trip_q[c];

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        high_side_gate[c] <= 1'b0;
        low_side_gate[c]  <= 1'b0;
      end else begin
        high_side_gate[c] <= run_ok & ramping & ~hold_q[c] & ~ov_trip; // [RULE_02] [RULE_07]
        low_side_gate[c]  <= ov_sink_q[c] | nl_sink_q[c] | ov_trip |
                             (run_ok & ramping & ~hold_q[c] & ~uv_trip_q[c]); // [RULE_16]
      end
    end

    // Out-of-window filter: count consecutive bad cycles, saturating.
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        pg_cnt_q[c] <= '0;
      end else if (!pgbad_s[c]) begin
        pg_cnt_q[c] <= '0;
      end else if (pg_cnt_q[c] != PG_W'(PG_CYCLES)) begin
        pg_cnt_q[c] <= pg_cnt_q[c] + PG_W'(1); // [RULE_10]
      end
    end

    // The run permit lets power-good fall on the same edge as ss_done, never after.
    assign pg_ok[c] = ss_done[c] & run_ok & en_s[c] &
                      (pg_cnt_q[c] != PG_W'(PG_CYCLES)); // [RULE_09]
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      power_good_out <= 1'b0;
    end else begin
      power_good_out <= &pg_ok & ~|ov_latched; // [RULE_08] [RULE_12]
    end
  end

  // The line is shared, so a pull from either channel pulls both pins.
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      enable_fault_line_oe  <= 2'h0;
      enable_fault_line_out <= 2'h0;
    end else begin
      enable_fault_line_oe  <= {2{|pull_ch}}; // [RULE_04] [RULE_12] [RULE_18]
      enable_fault_line_out <= 2'h0;
    end
  end

endmodule

`default_nettype wire

// ### rtl/sfs_sync.sv
// Purpose: Two-flop level synchroniser bank.
// Assumes: Inputs are quasi-static levels.
// Notes:   The first stage feeds only the second.
`timescale 1ns/100ps
`default_nettype none

module sfs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,   // Sampling clock.
  input  wire logic         rst_n, // Asynchronous reset, active low.
  input  wire logic [W-1:0] d,     // Asynchronous levels.
  output var  logic [W-1:0] q      // Synchronised levels.
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

`default_nettype wire

// ### testbench/sfs_far_side.sv
// Purpose: Other controllers sharing the enable/fault net.
// Assumes: Net has a pull-up; every member only pulls low.
// Notes:   pull_req stands for a fault in another controller.
`timescale 1ns/100ps
`default_nettype none

module sfs_far_side (
  input  wire logic       pull_req, // Another member pulls the net low.
  input  wire logic [1:0] dev_oe,   // Device pulling its pins low.
  output var  logic [1:0] line,     // Net level seen at both pins.
  output var  logic       far_on    // Other members still switching.
);
  // Both pins sit on one net, so a pull by anyone is seen at both.
  assign line = {2{~(pull_req | (|dev_oe))}};
  assign far_on = &line;
endmodule

`default_nettype wire

// ### testbench/sfs_sequencer_checker.sv
// Purpose: Port-level checks of the start-up and fault sequencer.
// Assumes: One clock domain; rst_n as seen at the top module.
// Notes:   Bound to every sfs_sequencer instance.
`timescale 1ns/100ps
`default_nettype none

module sfs_sequencer_checker #(
  parameter int SS_CYCLES = 16,
  parameter int SS_W      = 5
) (
  input wire logic                 sys_clk,                // Clock.
  input wire logic                 rst_n,                  // Reset.
  input wire logic                 vcc_por_ok,             // Supply.
  input wire logic [1:0]           enable_fault_line_in,   // Net level.
  input wire logic [1:0]           enable_fault_line_oe,   // Pull-down on.
  input wire logic [1:0]           en_sink_on,             // Sink on.
  input wire logic [1:0]           mon_out_of_window,      // Window fault.
  input wire logic [1:0]           ref_pin_band,           // Band strap.
  input wire logic                 ch2_neg_sense_near_vcc, // Mode strap.
  input wire logic [1:0]           high_side_gate,         // High gates.
  input wire logic [1:0][SS_W-1:0] ss_ref,                 // Ramp count.
  input wire logic [1:0]           ss_done,                // Ramp done.
  input wire logic [1:0]           ov_latched,             // OV latch.
  input wire logic                 power_good_out,         // Power-good.
  input wire logic                 multiphase_mode,        // Phases mode.
  input wire logic signed [9:0]    ch2_phase_deg           // Phase.
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_oow_long;
    (|mon_out_of_window) [*7];
  endsequence
  sequence s_oow_blip;
    $rose(|mon_out_of_window) ##1 (|mon_out_of_window) ##1 !(|mon_out_of_window);
  endsequence

  chk_gate_quick_off: assert property (!vcc_por_ok |-> ##[1:2] high_side_gate == 2'h0)
    else $error("high gate still on after supply loss");
  chk_pg_after_ss: assert property (power_good_out |-> ss_done == 2'h3)
    else $error("power-good before both ramps ended");
  chk_pg_line_gate: assert property (!(&enable_fault_line_in) |-> ##[1:4] !power_good_out)
    else $error("power-good kept with an enable low");
  chk_pg_filter_drop: assert property (s_oow_long |-> !power_good_out)
    else $error("power-good kept during lasting excursion");
  chk_pg_filter_blip: assert property (power_good_out ##0 s_oow_blip |-> ##3 power_good_out)
    else $error("power-good dropped on two-cycle excursion");
  chk_ov_gate_hold: assert property (ov_latched[0] |-> !high_side_gate[0])
    else $error("high gate on while latched off");
  chk_ov_line_pg: assert property (|ov_latched && vcc_por_ok |-> ##1 (enable_fault_line_oe == 2'h3 && !power_good_out))
    else $error("net or power-good not low after overvoltage");
  chk_ov_both_ch: assert property (multiphase_mode && $rose(ov_latched[0]) |-> ##[0:1] ov_latched[1])
    else $error("second channel kept running on overvoltage");
  chk_sink_off_run: assert property (power_good_out |-> en_sink_on == 2'h0)
    else $error("enable sink on while running");
  chk_ss_full_count: assert property (ss_done[0] |-> ss_ref[0] == SS_W'(SS_CYCLES))
    else $error("ramp done short of full count");
  chk_phase_ddr: assert property ((ref_pin_band == 2'h0 && !ch2_neg_sense_near_vcc) [*8] |-> ch2_phase_deg == -10'sh3c)
    else $error("wrong phase for lowest band");
endmodule

bind sfs_sequencer sfs_sequencer_checker #(.SS_CYCLES(SS_CYCLES), .SS_W(SS_W)) u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .vcc_por_ok(vcc_por_ok),
  .enable_fault_line_in(enable_fault_line_in), .enable_fault_line_oe(enable_fault_line_oe),
  .en_sink_on(en_sink_on), .mon_out_of_window(mon_out_of_window), .ref_pin_band(ref_pin_band),
  .ch2_neg_sense_near_vcc(ch2_neg_sense_near_vcc), .high_side_gate(high_side_gate),
  .ss_ref(ss_ref), .ss_done(ss_done), .ov_latched(ov_latched), .power_good_out(power_good_out),
  .multiphase_mode(multiphase_mode), .ch2_phase_deg(ch2_phase_deg));

`default_nettype wire

// ### testbench/sfs_sequencer_tb_top.sv
// Purpose: Self-checking bench for the start-up and fault sequencer.
// Assumes: Short delay and ramp counts so the run stays brief.
// Notes:   Inputs change 2 ns after each rising edge.
`timescale 1ns/100ps
`default_nettype none

module sfs_sequencer_tb_top;
  localparam int DLY = 8;
  localparam int SSC = 16;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic vcc_ok = 1'b0;
  logic pll = 1'b0;
  logic pull = 1'b1;
  logic near = 1'b0;
  logic fb2g = 1'b0;
  logic ot = 1'b0;
  logic [1:0] ov120 = 2'h0, ov113 = 2'h0, b87 = 2'h0, uv = 2'h0, oow = 2'h0, fbh = 2'h0;
  logic [1:0] band = 2'h0;
  logic [1:0] line, oe, lo, sink, hs, ls, ssd, ovl;
  logic [1:0][4:0] ssr;
  logic pg, two_ph, multi, far_on;
  logic signed [9:0] ph;
  logic signed [9:0] ph_exp [4] = '{-10'sh3c, 10'sh0, 10'sh5a, 10'shb4};
  int n_mismatch = 0;
  int samples_checked = 0;

  always #20 sys_clk = ~sys_clk;

  sfs_far_side u_far (.pull_req(pull), .dev_oe(oe), .line(line), .far_on(far_on));

  sfs_sequencer #(.DELAY_CYCLES(DLY), .SS_CYCLES(SSC)) u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .vcc_por_ok(vcc_ok), .driver_bias_supply_ok(vcc_ok),
    .pll_locked(pll), .enable_fault_line_in(line), .enable_fault_line_out(lo),
    .enable_fault_line_oe(oe), .en_sink_on(sink), .mon_ov120(ov120), .mon_ov113(ov113),
    .mon_below87(b87), .mon_uv(uv), .mon_out_of_window(oow), .fb_above_ss_ref(fbh),
    .oc_fault(2'h0), .ot_fault(ot), .pll_fault(1'b0), .ch2_neg_sense_near_vcc(near),
    .ch2_feedback_grounded(fb2g), .ch2_pos_sense_high(1'b0), .ref_pin_band(band),
    .high_side_gate(hs), .low_side_gate(ls), .ss_ref(ssr), .ss_done(ssd), .ov_latched(ovl),
    .power_good_out(pg), .two_phase_mode(two_ph), .multiphase_mode(multi), .ch2_phase_deg(ph));

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask

  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("wrong value at %0t ns: %s", $time, m);
    end
  endtask

  task automatic end_sim();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic wait_done(output int n);
    for (n = 0; n < 80 && ssd !== 2'h3; n++) begin
      tick(1);
      if (ssr[0] === 5'h08) begin
        chk(hs === 2'h2, "precharged channel switched early");
        fbh = 2'h0;
        uv = 2'h0;
      end
    end
  endtask

  task automatic t_start();
    int n;
    vcc_ok = 1'b1;
    pll = 1'b1;
    tick(12);
    chk(hs === 2'h0 && sink === 2'h3, "started with net held low");
    uv = 2'h3;
    fbh = 2'h1;
    pull = 1'b0;
    wait_done(n);
    chk(n >= DLY + SSC && n <= DLY + SSC + 10, "start-up length");
    chk(oe === 2'h0 && hs === 2'h3, "undervoltage armed in ramp");
    tick(4);
    chk(pg === 1'b1 && sink === 2'h0, "power-good or sink after start");
  endtask

  task automatic t_glitch();
    oow = 2'h2;
    tick(2);
    oow = 2'h0;
    tick(6);
    chk(pg === 1'b1, "power-good dropped on short excursion");
    oow = 2'h2;
    tick(8);
    chk(pg === 1'b0, "power-good held during lasting excursion");
    oow = 2'h0;
    tick(8);
    chk(pg === 1'b1, "power-good did not return");
  endtask

  task automatic t_phase();
    int b;
    for (b = 0; b < 4; b++) begin
      band = 2'(b);
      tick(8);
      chk(ph === ph_exp[b], "phase for reference band");
    end
  endtask

  task automatic t_far_fault();
    int n;
    pull = 1'b1;
    tick(2);
    chk(hs === 2'h0 && ls === 2'h0, "gates on after net pulled low");
    ov113 = 2'h3;
    tick(4);
    chk(ls === 2'h3 && ssd === 2'h0 && pg === 1'b0, "no low gate at 113 percent");
    ov113 = 2'h0;
    b87 = 2'h3;
    tick(4);
    chk(ls === 2'h0, "low gate kept below 87 percent");
    b87 = 2'h0;
    fbh = 2'h1;
    pull = 1'b0;
    wait_done(n);
    tick(4);
    uv = 2'h1;
    tick(5);
    chk(ls === 2'h0 && oe === 2'h3 && pg === 1'b0, "undervoltage response");
    uv = 2'h0;
    fbh = 2'h1;
    wait_done(n);
    tick(4);
    ot = 1'b1;
    tick(4);
    chk(oe === 2'h3 && hs === 2'h0, "net not pulled on over-temperature");
    ot = 1'b0;
  endtask

  task automatic t_ov();
    near = 1'b1;
    tick(8);
    chk(ph === 10'shf0 && two_ph === 1'b0, "3-phase strap");
    fb2g = 1'b1;
    tick(8);
    chk(two_ph === 1'b1 && multi === 1'b1 && ph === 10'shb4, "2-phase strap");
    ov120 = 2'h1;
    tick(4);
    chk(ovl === 2'h3 && hs === 2'h0 && ls === 2'h3, "overvoltage latch");
    chk(oe === 2'h3 && lo === 2'h0 && pg === 1'b0 && far_on === 1'b0, "net after overvoltage");
    ov120 = 2'h0;
    b87 = 2'h3;
    tick(4);
    chk(ls === 2'h0 && ovl === 2'h3 && hs === 2'h0, "latch release");
    vcc_ok = 1'b0;
    tick(4);
    vcc_ok = 1'b1;
    tick(6);
    chk(ovl === 2'h0, "latch kept over supply cycle");
  endtask

  initial begin
    tick(3);
    rst_n = 1'b1;
    t_start();
    t_glitch();
    t_phase();
    t_far_fault();
    t_ov();
    end_sim();
  end

  // Whole run is a few hundred cycles; this allows several times that.
  initial begin
    #80000;
    n_mismatch++;
    end_sim();
  end
endmodule

`default_nettype wire
